// [logic/fsos_flash_seq.sv]
`timescale 1ns/100ps
module fsos_flash_seq
   import fsos_pkg::*;
#(
   parameter int BLOCK_ERASE_CYC_P = BLOCK_ERASE_CYC,
   parameter int FULL_ERASE_CYC_P = FULL_ERASE_CYC,
   parameter int OTP_PROGRAM_CYC_P = OTP_PROGRAM_CYC
)(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   output logic spi_so_o,
   output logic spi_so_oe_o,
   output logic op_in_progress_flag_o,
   output logic write_latch_flag_o,
   output logic row_locked_o,
   output logic [7:0] erase_block_o
);
   fsos_frame_t frame_q;
   fsos_op_t op_q;
   fsos_kind_t kind_q;
   logic [7:0] opcode_q;
   logic opc_ok_q;
   logic [23:0] addr_q;
   logic [9:0] ptr_q;
   logic wel_q;
   logic [31:0] timer_q;
   logic [15:0] susp_cnt_q;
   logic [7:0] row_q [ROW_ENTRIES];
   logic [7:0] buf_q [ROW_ENTRIES];
   logic [ROW_ENTRIES-1:0] mask_q;
   logic [7:0] sh_q;

   logic rx_start;
   logic rx_end;
   logic rx_fall;
   logic rx_done;
   logic [7:0] rx_byte;
   logic [2:0] rx_bits;
   logic [8:0] rx_bytes;

   logic fin;
   logic go_wel;
   logic go_block;
   logic go_full;
   logic go_row;
   logic go_suspend;
   logic go_resume;
   logic done;
   logic commit;
   logic susp_ready;
   logic locked;
   logic op_in_progress_flag;
   logic data_start;
   logic data_wr;
   logic out_load;
   logic [23:0] new_addr;
   logic [7:0] status_byte;
   logic [7:0] next_out;

   fsos_spi_rx u_rx (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .spi_clk_i(spi_clk_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_si_i(spi_si_i),
      .frame_start_o(rx_start),
      .frame_end_o(rx_end),
      .sck_fall_o(rx_fall),
      .byte_done_o(rx_done),
      .byte_o(rx_byte),
      .bit_cnt_o(rx_bits),
      .byte_cnt_o(rx_bytes)
   );

   function automatic logic is_suspend(input logic [7:0] opc);
      is_suspend = opc == OPC_SUSPEND_A || opc == OPC_SUSPEND_B;
   endfunction

   function automatic logic is_resume(input logic [7:0] opc);
      is_resume = opc == OPC_RESUME_A || opc == OPC_RESUME_B;
   endfunction

   // Which opcodes the current operation state lets through
   function automatic logic cmd_allowed(input logic [7:0] opc, input fsos_op_t op, input fsos_kind_t kind);
      logic rd;
      rd = opc inside {OPC_READ, OPC_FAST_READ, OPC_DUAL_IO_READ, OPC_QUAD_IO_READ, OPC_STATUS_READ,
                       OPC_RELEASE_ID, OPC_JEDEC_ID, OPC_MAKER_ID, OPC_ROW_READ};
      unique case (op)
         OP_IDLE: cmd_allowed = 1'b1;
         OP_BUSY: cmd_allowed = opc == OPC_STATUS_READ || (is_suspend(opc) && kind != K_FULL);
         OP_SUSPENDING: cmd_allowed = opc == OPC_STATUS_READ;
         OP_SUSPENDED: cmd_allowed = rd || is_resume(opc);
      endcase
   endfunction

   always_comb begin
      fin = rx_end && opc_ok_q && rx_bits == 3'h0;
      go_wel = fin && op_q == OP_IDLE && opcode_q == OPC_SET_WRITE_LATCH && rx_bytes == SINGLE_CMD_BYTES;
      go_block = fin && op_q == OP_IDLE && wel_q && opcode_q == OPC_BLOCK_ERASE
                 && rx_bytes == ADDR_CMD_BYTES;
      go_full = fin && op_q == OP_IDLE && wel_q && opcode_q == OPC_FULL_ERASE
                && rx_bytes == SINGLE_CMD_BYTES;
      go_row = fin && op_q == OP_IDLE && wel_q && !locked && opcode_q == OPC_ROW_PROG
               && rx_bytes > ADDR_CMD_BYTES;
      go_suspend = fin && op_q == OP_BUSY && kind_q != K_FULL && is_suspend(opcode_q)
                   && rx_bytes == SINGLE_CMD_BYTES;
      go_resume = fin && op_q == OP_SUSPENDED && is_resume(opcode_q) && rx_bytes == SINGLE_CMD_BYTES;
      done = ce_i && op_q == OP_BUSY && !go_suspend && timer_q <= 32'h1;
      commit = done && kind_q == K_ROW;
      susp_ready = ce_i && op_q == OP_SUSPENDING && susp_cnt_q >= 16'(SUSPEND_READY_CYC - 1);
      locked = ~row_q[ROW_CTRL_IDX][ROW_LOCK_BIT];
      op_in_progress_flag = op_q == OP_BUSY || op_q == OP_SUSPENDING;
      new_addr = {addr_q[15:0], rx_byte};
      data_start = rx_done && frame_q == FR_ADDR && rx_bytes == ADDR_CMD_BYTES - 9'h001
                   && opcode_q == OPC_ROW_PROG;
      data_wr = rx_done && frame_q == FR_DATA && ptr_q <= 10'(ROW_CTRL_ADDR);
      out_load = rx_fall && frame_q == FR_OUT && rx_bits == 3'h0;
      status_byte = 8'h00;
      status_byte[STAT_WIP_BIT] = op_in_progress_flag;
      status_byte[STAT_WEL_BIT] = wel_q;
      // Beyond the row the pins read as erased
      next_out = ptr_q <= 10'(ROW_CTRL_ADDR) ? row_q[ptr_q[8:0]] : ROW_ERASED;
      if (opcode_q == OPC_STATUS_READ) begin
         next_out = status_byte;
      end
   end

   // Frame decode
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         frame_q <= FR_IDLE;
         opcode_q <= 8'h00;
         opc_ok_q <= 1'b0;
         addr_q <= 24'h000000;
      end else if (ce_i) begin
         if (rx_start) begin
            frame_q <= FR_OPCODE;
            opc_ok_q <= 1'b0;
         end else if (rx_end) begin
            frame_q <= FR_IDLE;
         end else if (rx_done) begin
            unique case (frame_q)
               FR_OPCODE: begin
                  opcode_q <= rx_byte;
                  opc_ok_q <= cmd_allowed(rx_byte, op_q, kind_q);
                  if (!cmd_allowed(rx_byte, op_q, kind_q)) begin
                     frame_q <= FR_HOLD;
                  end else if (rx_byte == OPC_STATUS_READ) begin
                     frame_q <= FR_OUT;
                  end else if (rx_byte inside {OPC_BLOCK_ERASE, OPC_ROW_PROG, OPC_ROW_READ}) begin
                     frame_q <= FR_ADDR;
                  end else begin
                     frame_q <= FR_HOLD;
                  end
               end
               FR_ADDR: begin
                  addr_q <= new_addr;
                  if (rx_bytes == ADDR_CMD_BYTES - 9'h001) begin
                     if (opcode_q == OPC_ROW_PROG) begin
                        frame_q <= FR_DATA;
                     end else if (opcode_q == OPC_ROW_READ) begin
                        frame_q <= FR_OUT;
                     end else begin
                        frame_q <= FR_HOLD;
                     end
                  end
               end
               FR_IDLE, FR_DATA, FR_OUT, FR_HOLD: begin
               end
            endcase
         end
      end
   end

   // Row pointer: saturates instead of wrapping, for program and read alike
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr_q <= ROW_PTR_NONE;
      end else if (ce_i) begin
         if (rx_done && frame_q == FR_ADDR && rx_bytes == ADDR_CMD_BYTES - 9'h001) begin
            ptr_q <= new_addr > ROW_CTRL_ADDR ? ROW_PTR_NONE : 10'(new_addr);
         end else if (rx_done && frame_q == FR_DATA && ptr_q != ROW_PTR_NONE) begin
            ptr_q <= ptr_q + 10'h001;
         end else if (out_load && opcode_q == OPC_ROW_READ && ptr_q != 10'(ROW_LAST_ADDR)
                      && ptr_q < 10'(ROW_CTRL_ADDR)) begin
            ptr_q <= ptr_q + 10'h001;
         end
      end
   end

   // Staging buffer; contents only matter where the mask is set
   always_ff @(posedge clk_i) begin
      if (ce_i && data_wr) begin
         buf_q[ptr_q[8:0]] <= rx_byte;
      end
   end

   // Power-on models a blank row, lock included
   for (genvar i = 0; i < ROW_ENTRIES; i++) begin : g_row
      always_ff @(posedge clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            row_q[i] <= ROW_ERASED;
            mask_q[i] <= 1'b0;
         end else if (ce_i) begin
            if (commit && mask_q[i]) begin
               row_q[i] <= row_q[i] & buf_q[i];
            end
            if (data_start) begin
               mask_q[i] <= 1'b0;
            end else if (data_wr && ptr_q == 10'(i)) begin
               mask_q[i] <= 1'b1;
            end
         end
      end
   end

   // Operation engine; a suspend freezes the remaining count so the total is unchanged
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         op_q <= OP_IDLE;
         kind_q <= K_NONE;
         timer_q <= 32'h0;
         susp_cnt_q <= 16'h0;
         erase_block_o <= 8'h00;
      end else if (ce_i) begin
         unique case (op_q)
            OP_IDLE: begin
               if (go_block) begin
                  op_q <= OP_BUSY;
                  kind_q <= K_BLOCK;
                  timer_q <= 32'(BLOCK_ERASE_CYC_P);
                  erase_block_o <= addr_q[23:16];
               end else if (go_full) begin
                  op_q <= OP_BUSY;
                  kind_q <= K_FULL;
                  timer_q <= 32'(FULL_ERASE_CYC_P);
               end else if (go_row) begin
                  op_q <= OP_BUSY;
                  kind_q <= K_ROW;
                  timer_q <= 32'(OTP_PROGRAM_CYC_P);
               end
            end
            OP_BUSY: begin
               if (go_suspend) begin
                  op_q <= OP_SUSPENDING;
                  susp_cnt_q <= 16'h0;
               end else if (timer_q <= 32'h1) begin
                  op_q <= OP_IDLE;
                  kind_q <= K_NONE;
                  timer_q <= 32'h0;
               end else begin
                  timer_q <= timer_q - 32'h1;
               end
            end
            OP_SUSPENDING: begin
               susp_cnt_q <= susp_cnt_q + 16'h1;
               if (susp_ready) begin
                  op_q <= OP_SUSPENDED;
               end
            end
            OP_SUSPENDED: begin
               if (go_resume) begin
                  op_q <= OP_BUSY;
               end
            end
         endcase
      end
   end

   // Write latch; set and clear never coincide since set needs an idle engine and its own opcode
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wel_q <= 1'b0;
      end else if (ce_i) begin
         if (go_wel) begin
            wel_q <= 1'b1;
         end else if (go_row) begin
            wel_q <= 1'b0;
         end else if (done && kind_q != K_ROW) begin
            wel_q <= 1'b0;
         end else if (susp_ready) begin
            wel_q <= 1'b0;
         end
      end
   end

   // Output shifter; changes on falling clock so modes 0 and 3 both see stable data
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sh_q <= 8'h00;
         spi_so_o <= 1'b0;
         spi_so_oe_o <= 1'b0;
         op_in_progress_flag_o <= 1'b0;
         write_latch_flag_o <= 1'b0;
         row_locked_o <= 1'b0;
      end else if (ce_i) begin
         spi_so_oe_o <= frame_q == FR_OUT;
         op_in_progress_flag_o <= op_in_progress_flag;
         write_latch_flag_o <= wel_q;
         row_locked_o <= locked;
         if (out_load) begin
            spi_so_o <= next_out[7];
            sh_q <= {next_out[6:0], 1'b0};
         end else if (rx_fall && frame_q == FR_OUT) begin
            spi_so_o <= sh_q[7];
            sh_q <= {sh_q[6:0], 1'b0};
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_block_needs_wel: assert property (
      $past(op_q) == OP_IDLE && op_q == OP_BUSY && kind_q == K_BLOCK |-> $past(wel_q))
      else $error("block erase started without write latch");
   a_wel_after_erase: assert property (
      done && kind_q != K_ROW |=> !wel_q && op_q == OP_IDLE)
      else $error("write latch still set after erase end");
   a_start_at_end: assert property (
      $past(op_q) == OP_IDLE && op_q == OP_BUSY |-> $past(rx_end && rx_bits == 3'h0))
      else $error("operation started outside a whole-byte frame end");
   a_row_lock: assert property (
      kind_q == K_ROW && $past(kind_q) != K_ROW |-> !$past(locked))
      else $error("row program started on a locked row");
   a_lock_sticky: assert property (
      locked |=> locked)
      else $error("row lock returned to one");
   a_no_wrap: assert property (
      ce_i && rx_done && frame_q == FR_DATA |=> ptr_q >= $past(ptr_q))
      else $error("row pointer wrapped");
   a_wel_row_busy: assert property (
      op_q == OP_BUSY && kind_q == K_ROW |-> !wel_q)
      else $error("write latch set during row program");
   a_suspend_bound: assert property (
      op_q == OP_SUSPENDING |-> susp_cnt_q < 16'(SUSPEND_READY_CYC))
      else $error("suspend took too long");
   a_suspended_wel: assert property (
      op_q == OP_SUSPENDED |-> !wel_q && kind_q != K_FULL)
      else $error("write latch set while suspended");
   a_busy_filter: assert property (
      ce_i && op_q == OP_BUSY && rx_done && frame_q == FR_OPCODE
      |=> !opc_ok_q || opcode_q == OPC_STATUS_READ || is_suspend(opcode_q))
      else $error("command accepted during busy cycle");
   a_timer_frozen: assert property (
      op_q inside {OP_SUSPENDING, OP_SUSPENDED} |=> timer_q == $past(timer_q))
      else $error("remaining time moved while suspended");
   a_wip_flag: assert property (
      ce_i && op_q == OP_BUSY |=> op_in_progress_flag_o)
      else $error("progress flag low while busy");
   a_read_sat: assert property (
      out_load && opcode_q == OPC_ROW_READ && ptr_q == 10'(ROW_LAST_ADDR) |=> ptr_q == 10'(ROW_LAST_ADDR))
      else $error("row read moved past the last byte");
endmodule

// [inc/fsos_pkg.sv]
package fsos_pkg;
   // Command opcodes
   localparam logic [7:0] OPC_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] OPC_BLOCK_ERASE = 8'hd8;
   localparam logic [7:0] OPC_FULL_ERASE = 8'hc7;
   localparam logic [7:0] OPC_ROW_PROG = 8'h42;
   localparam logic [7:0] OPC_ROW_READ = 8'h4b;
   localparam logic [7:0] OPC_STATUS_READ = 8'h05;
   localparam logic [7:0] OPC_SUSPEND_A = 8'h75;
   localparam logic [7:0] OPC_SUSPEND_B = 8'hb0;
   localparam logic [7:0] OPC_RESUME_A = 8'h7a;
   localparam logic [7:0] OPC_RESUME_B = 8'h30;
   localparam logic [7:0] OPC_READ = 8'h03;
   localparam logic [7:0] OPC_FAST_READ = 8'h0b;
   localparam logic [7:0] OPC_DUAL_IO_READ = 8'hbb;
   localparam logic [7:0] OPC_QUAD_IO_READ = 8'heb;
   localparam logic [7:0] OPC_RELEASE_ID = 8'hab;
   localparam logic [7:0] OPC_JEDEC_ID = 8'h9f;
   localparam logic [7:0] OPC_MAKER_ID = 8'h90;

   // Frame lengths in whole bytes
   localparam logic [8:0] SINGLE_CMD_BYTES = 9'h001;
   localparam logic [8:0] ADDR_CMD_BYTES = 9'h004;

   // Security row layout
   localparam logic [23:0] ROW_LAST_ADDR = 24'h0000ff;
   localparam logic [23:0] ROW_CTRL_ADDR = 24'h000100;
   localparam int ROW_CTRL_IDX = int'(ROW_CTRL_ADDR);
   localparam int ROW_ENTRIES = ROW_CTRL_IDX + 1;
   localparam int ROW_LOCK_BIT = 0;
   localparam logic [7:0] ROW_ERASED = 8'hff;
   localparam logic [9:0] ROW_PTR_NONE = 10'h3ff;

   // Status byte fields
   localparam int STAT_WIP_BIT = 0;
   localparam int STAT_WEL_BIT = 1;

   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int BLOCK_ERASE_MS = 250;
   localparam int FULL_ERASE_MS = 1000;
   localparam int OTP_PROGRAM_US = 500;
   localparam int SUSPEND_READY_US = 20;
   localparam int RESUME_TO_SUSPEND_MS = 1;
   localparam int WRITE_TO_SUSPEND_NS = 500;
   localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int FULL_ERASE_CYC = FULL_ERASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int OTP_PROGRAM_CYC = OTP_PROGRAM_US * 1000 / CLK_PERIOD_NS;
   localparam int SUSPEND_READY_CYC = SUSPEND_READY_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {FR_IDLE, FR_OPCODE, FR_ADDR, FR_DATA, FR_OUT, FR_HOLD} fsos_frame_t;
   typedef enum logic [1:0] {OP_IDLE, OP_BUSY, OP_SUSPENDING, OP_SUSPENDED} fsos_op_t;
   typedef enum logic [1:0] {K_NONE, K_BLOCK, K_FULL, K_ROW} fsos_kind_t;
endpackage

// [logic/fsos_spi_rx.sv]
`timescale 1ns/100ps
module fsos_spi_rx
   import fsos_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   output logic frame_start_o,
   output logic frame_end_o,
   output logic sck_fall_o,
   output logic byte_done_o,
   output logic [7:0] byte_o,
   output logic [2:0] bit_cnt_o,
   output logic [8:0] byte_cnt_o
);
   // Bit order in both stages: clock, select, data
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic sck_prev_q;
   logic cs_prev_q;
   logic end1_q;
   logic [6:0] shift_q;
   logic sck_rise;

   // Gated by the previous select sample so a last edge next to the select rising still counts
   assign sck_rise = sync2_q[2] & ~sck_prev_q & ~cs_prev_q;
   assign sck_fall_o = ~sync2_q[2] & sck_prev_q & ~cs_prev_q;
   assign frame_start_o = ~sync2_q[1] & cs_prev_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= 3'h2;
         sync2_q <= 3'h2;
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
         end1_q <= 1'b0;
         frame_end_o <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= {spi_clk_i, spi_cs_n_i, spi_si_i};
         sync2_q <= sync1_q;
         sck_prev_q <= sync2_q[2];
         cs_prev_q <= sync2_q[1];
         // Two stages so the last byte is counted before the end is judged
         end1_q <= sync2_q[1] & ~cs_prev_q;
         frame_end_o <= end1_q;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_q <= 7'h00;
         byte_o <= 8'h00;
         byte_done_o <= 1'b0;
         bit_cnt_o <= 3'h0;
         byte_cnt_o <= 9'h000;
      end else if (ce_i) begin
         byte_done_o <= 1'b0;
         if (frame_start_o) begin
            bit_cnt_o <= 3'h0;
            byte_cnt_o <= 9'h000;
         end else begin
            if (sck_rise) begin
               shift_q <= {shift_q[5:0], sync2_q[0]};
               bit_cnt_o <= bit_cnt_o + 3'h1;
               if (bit_cnt_o == 3'h7) begin
                  byte_o <= {shift_q, sync2_q[0]};
                  byte_done_o <= 1'b1;
               end
            end
            if (byte_done_o && byte_cnt_o != 9'h1ff) begin
               byte_cnt_o <= byte_cnt_o + 9'h001;
            end
         end
      end
   end
endmodule

// [testbench/fsos_spi_host.sv]
`timescale 1ns/100ps
module fsos_spi_host (
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_si_o,
   input wire logic spi_so_i
);
   logic cpol;
   initial begin
      cpol = 1'b0;
      spi_clk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_si_o = 1'b0;
   end
   // The clock stands still at its idle level between frames; that level picks mode 0 or 3
   task automatic set_mode(input logic m);
      cpol = m;
      spi_clk_o = m;
   endtask
   // Caller starts frames on a falling system clock edge
   task automatic sel();
      spi_cs_n_o = 1'b0;
      #100;
   endtask
   // Released data line flips so a stale bit is never mistaken for data
   task automatic desel();
      #100 spi_cs_n_o = 1'b1;
      spi_si_o = ~spi_si_o;
      #300;
   endtask
   // Read bit taken just before the rise, after the device has had a low half period
   task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
      q = 8'h00;
      for (int i = 7; i >= 8 - n; i--) begin
         if (cpol) begin
            spi_clk_o = 1'b0;
         end
         spi_si_o = d[i];
         #100 q[i] = spi_so_i;
         spi_clk_o = 1'b1;
         #100;
         if (!cpol) begin
            spi_clk_o = 1'b0;
         end
      end
   endtask
endmodule

// [testbench/fsos_flash_seq_tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module fsos_flash_seq_tb;
   import fsos_pkg::*;
   localparam int BLK = 2000;
   localparam int FULL = 300;
   localparam int OTP = 100;
   logic clk_i, reset_n_i, ce_i, spi_clk, spi_cs_n, spi_si, spi_so, spi_so_oe, busy, latch, locked;
   logic [7:0] blk;
   logic [7:0] rd[$];
   int bad_count, compares, cyc;
   fsos_flash_seq #(.BLOCK_ERASE_CYC_P(BLK), .FULL_ERASE_CYC_P(FULL), .OTP_PROGRAM_CYC_P(OTP)) dut (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .spi_clk_i(spi_clk), .spi_cs_n_i(spi_cs_n),
      .spi_si_i(spi_si), .spi_so_o(spi_so), .spi_so_oe_o(spi_so_oe), .op_in_progress_flag_o(busy),
      .write_latch_flag_o(latch), .row_locked_o(locked), .erase_block_o(blk));
   // Released output reads as pulled up, so stale data is never taken
   fsos_spi_host host (.spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .spi_si_o(spi_si),
      .spi_so_i(spi_so_oe ? spi_so : 1'b1));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic end_sim();
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Ceiling well above the sum of all erase, program and frame times
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic frame(input logic [7:0] b[$], input int nrd = 0, input int tail = 0);
      logic [7:0] q;
      @(negedge clk_i);
      host.sel();
      foreach (b[i]) host.shift(b[i], 8, q);
      if (tail > 0) host.shift(8'h00, tail, q);
      rd = {};
      for (int i = 0; i < nrd; i++) begin
         host.shift(8'h00, 8, q);
         rd.push_back(q);
         `CHK(spi_so_oe, 1'b1)
      end
      host.desel();
   endtask
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      `CHK(busy, v)
   endtask
   task automatic t_erase();
      frame('{OPC_BLOCK_ERASE, 8'h05, 8'h00, 8'h00});
      `CHK(busy, 1'b0)
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_BLOCK_ERASE, 8'h05, 8'h00, 8'h00});
      `CHK(busy, 1'b1)
      `CHK(blk, 8'h05)
      frame('{OPC_ROW_PROG, 8'h00, 8'h00, 8'h20, 8'h00});
      `CHK(busy, 1'b1)
      frame('{OPC_STATUS_READ}, 1);
      `CHK(rd[0], 8'h03)
      wait_busy(1'b0, BLK + 20);
      `CHK(latch, 1'b0)
      frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'h20}, 1);
      `CHK(rd[0], ROW_ERASED)
   endtask
   // Runs in mode 3 and freezes the engine with the clock enable mid-erase
   task automatic t_full();
      host.set_mode(1'b1);
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_FULL_ERASE, 8'h00});
      `CHK(busy, 1'b0)
      frame('{OPC_FULL_ERASE});
      `CHK(busy, 1'b1)
      `CHK(latch, 1'b1)
      frame('{OPC_STATUS_READ}, 1);
      `CHK(rd[0], 8'h03)
      ce_i = 1'b0;
      repeat (FULL + 100) @(negedge clk_i);
      ce_i = 1'b1;
      repeat (10) @(negedge clk_i);
      `CHK(busy, 1'b1)
      wait_busy(1'b0, FULL + 20);
      `CHK(latch, 1'b0)
      host.set_mode(1'b0);
   endtask
   // Each pair uses a fresh erase; the second waits out the resume-to-suspend gap first
   task automatic t_suspend();
      logic [7:0] sus, res;
      for (int i = 0; i < 2; i++) begin
         if (i > 0) begin
            repeat (RESUME_TO_SUSPEND_MS * 1000000 / CLK_PERIOD_NS) @(negedge clk_i);
         end
         sus = i ? OPC_SUSPEND_B : OPC_SUSPEND_A;
         res = i ? OPC_RESUME_B : OPC_RESUME_A;
         frame('{OPC_SET_WRITE_LATCH});
         frame('{OPC_BLOCK_ERASE, 8'h00, 8'h01, 8'h00});
         #500;
         frame('{sus});
         `CHK(busy, 1'b1)
         wait_busy(1'b0, SUSPEND_READY_CYC + 20);
         `CHK(latch, 1'b0)
         frame('{OPC_SET_WRITE_LATCH});
         `CHK(latch, 1'b0)
         frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'h00}, 1);
         `CHK(rd[0], ROW_ERASED)
         frame('{res});
         `CHK(busy, 1'b1)
         wait_busy(1'b0, BLK + 20);
      end
   endtask
   task automatic t_row();
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_ROW_PROG, 8'h00, 8'h00, 8'hfe, 8'ha5, 8'h3c, 8'hc3, 8'h00});
      `CHK(latch, 1'b0)
      `CHK(busy, 1'b1)
      wait_busy(1'b0, OTP + 20);
      frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'hfe}, 4);
      `CHK(rd[0], 8'ha5)
      `CHK(rd[2], 8'h3c)
      `CHK(rd[3], 8'h3c)
      frame('{OPC_ROW_READ, 8'h00, 8'h01, 8'h00}, 1);
      `CHK(rd[0], 8'hc3)
      frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'h00}, 1);
      `CHK(rd[0], ROW_ERASED)
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_ROW_PROG, 8'h00, 8'h00, 8'h10, 8'h55}, 0, 4);
      `CHK(busy, 1'b0)
      frame('{OPC_ROW_PROG, 8'h00, 8'h00, 8'hfe, 8'h0f});
      wait_busy(1'b0, OTP + 20);
      frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'hfe}, 1);
      `CHK(rd[0], 8'h05)
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_ROW_PROG, 8'h00, 8'h01, 8'h00, 8'hfe});
      wait_busy(1'b0, OTP + 20);
      `CHK(locked, 1'b1)
      frame('{OPC_SET_WRITE_LATCH});
      frame('{OPC_ROW_PROG, 8'h00, 8'h00, 8'h00, 8'h00});
      `CHK(busy, 1'b0)
      frame('{OPC_ROW_READ, 8'h00, 8'h00, 8'h00}, 1);
      `CHK(rd[0], ROW_ERASED)
   endtask
   initial begin
      reset_n_i = 1'b0;
      ce_i = 1'b1;
      repeat (6) @(posedge clk_i);
      @(negedge clk_i) reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      `CHK(busy, 1'b0)
      `CHK(latch, 1'b0)
      t_erase();
      t_full();
      t_suspend();
      t_row();
      end_sim();
   end
endmodule
